/* rtl/sbc_map.vh */
// Register map, field positions, reset values and timing of the config bank
`ifndef SBC_MAP_VH
`define SBC_MAP_VH
// Register indices; byte address is four times the index
`define SBC_IDX_BUSWIN0      16'hff0c
`define SBC_IDX_SYSCFG       16'hff12
`define SBC_IDX_BUSWIN1      16'hff14
`define SBC_IDX_BUSWIN2      16'hff16
`define SBC_IDX_BUSWIN3      16'hff18
`define SBC_IDX_STATUS       16'hff1a
`define SBC_ADDR_W           18
// System config fields
`define SBC_SC_SHARE         0
`define SBC_SC_VISIBLE       1
`define SBC_SC_PERIPH_ON     2
`define SBC_SC_BIDIR         3
`define SBC_SC_OSCWD_OFF     4
`define SBC_SC_PDN_MODE      5
`define SBC_SC_CS_UNLATCH    6
`define SBC_SC_WR_SPLIT      7
`define SBC_SC_CLK_OUT       8
`define SBC_SC_HB_OFF        9
`define SBC_SC_MEM_ON        10
`define SBC_SC_SEG_OFF       11
`define SBC_SC_FLASH_HI      12
`define SBC_SC_STK_LO        13
`define SBC_SC_RESET         16'h0000
// Bus window fields
`define SBC_BW_WAIT_LO       0
`define SBC_BW_CMD_DLY       4
`define SBC_BW_TRI_WAIT      5
`define SBC_BW_TYPE_LO       6
`define SBC_BW_ALE_LONG      9
`define SBC_BW_ACTIVE        10
`define SBC_BW_RDY_ON        12
`define SBC_BW_RDY_POL       13
`define SBC_BW_RESET         16'h0000
`define SBC_BW_WMASK         16'hf6ff
`define SBC_SC_WMASK         16'hffff
// Stack tops and flash segment bases
`define SBC_STACK_TOP        16'hfbfe
`define SBC_STACK_TOP_1K     16'hfdfe
`define SBC_FLASH_SEG0       24'h000000
`define SBC_FLASH_SEG1       24'h010000
// Timing
`define SBC_CLK_NS           8
`define SBC_BIDIR_PHASES     1024
`define SBC_BIDIR_CYC        (`SBC_BIDIR_PHASES / 2)
`define SBC_OWD_IDLE_NS      1000
`define SBC_OWD_IDLE_CYC     ((`SBC_OWD_IDLE_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
// AXI responses
`define SBC_RESP_OKAY        2'b00
`define SBC_RESP_DECERR      2'b11
`endif

/* rtl/sbc_regs.v */
// System and bus window configuration register bank with AXI4-Lite access
`include "sbc_map.vh"
`default_nettype none
module sbc_regs #(
  parameter integer BIDIR_CYCLES = `SBC_BIDIR_CYC,
  parameter integer IRQ_PINS     = 8
) (
  input  wire                      core_clk,
  input  wire                      rst_n,
  input  wire [`SBC_ADDR_W-1:0]    s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output wire                      s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output wire                      s_axi_wready,
  output wire [1:0]                s_axi_bresp,
  output wire                      s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [`SBC_ADDR_W-1:0]    s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output wire                      s_axi_arready,
  output wire [31:0]               s_axi_rdata,
  output wire [1:0]                s_axi_rresp,
  output wire                      s_axi_rvalid,
  input  wire                      s_axi_rready,
  input  wire                      end_of_init_instr,
  input  wire                      power_down_instr,
  input  wire                      soft_reset_req,
  input  wire                      external_access_pin,
  input  wire [1:0]                strap_bus_type,
  input  wire                      strap_write_config,
  input  wire                      crystal_input,
  input  wire                      pll_bypass,
  input  wire                      nmi_pin_n,
  input  wire [IRQ_PINS-1:0]       fast_ext_irq_pin,
  input  wire [IRQ_PINS-1:0]       fast_irq_enable,
  input  wire [IRQ_PINS-1:0]       fast_irq_high_active,
  input  wire                      hold_mode,
  input  wire [1:0]                bus_cycle_window,
  input  wire                      ready_pin,
  output wire                      reset_input_pin_out,
  output wire                      reset_input_pin_oe,
  output wire                      ext_master_access_ok,
  output wire                      ext_periph_visible,
  output wire                      ext_periph_on,
  output wire                      cpu_clk_from_pll,
  output wire                      pll_off,
  output wire                      power_down,
  output wire                      chip_select_unlatched,
  output wire                      low_byte_write_strobe,
  output wire                      high_byte_write_strobe,
  output wire                      clock_output_on,
  output wire                      high_byte_pin_off,
  output wire                      internal_memory_on,
  output wire                      save_code_segment,
  output wire [23:0]               flash_base,
  output wire [11:0]               stack_pointer_mask,
  output wire [15:0]               stack_top,
  output wire                      stack_circular,
  output wire                      bus_width16,
  output wire                      bus_multiplexed,
  output wire [3:0]                wait_states,
  output wire                      rw_cmd_delayed,
  output wire                      bus_cycle_may_end
);

  reg  [15:0] syscfg_reg;
  reg  [15:0] win_reg [0:3];
  reg         lock_reg;
  reg         init_reg;
  reg         awfull_reg;
  reg         wfull_reg;
  reg  [15:0] awidx_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;
  reg  [1:0]  rresp_reg;
  reg  [9:0]  pull_cnt_reg;
  reg         pull_reg;
  reg         xtal_prev_reg;
  reg  [7:0]  idle_cnt_reg;
  reg         pll_sel_reg;
  reg         pll_off_reg;
  reg         pdn_reg;
  reg  [IRQ_PINS-1:0] irq_prev_reg;
  reg         share_reg;
  reg         lo_wr_reg;
  reg         hi_wr_reg;
  reg  [23:0] flash_reg;
  reg  [11:0] spmask_reg;
  reg  [15:0] sptop_reg;
  reg         circ_reg;
  reg         w16_reg;
  reg         mux_reg;
  reg  [3:0]  ws_reg;
  reg         rwd_reg;
  reg         end_reg;

  // Index of a register from its byte address; unmapped gives all ones
  function [2:0] sbc_decode;
    input [`SBC_ADDR_W-1:0] addr;
    reg   [15:0]            idx;
    begin
      idx = addr[`SBC_ADDR_W-1:2];
      if (idx == `SBC_IDX_BUSWIN0)
        sbc_decode = 3'h0;
      else if (idx == `SBC_IDX_BUSWIN1)
        sbc_decode = 3'h1;
      else if (idx == `SBC_IDX_BUSWIN2)
        sbc_decode = 3'h2;
      else if (idx == `SBC_IDX_BUSWIN3)
        sbc_decode = 3'h3;
      else if (idx == `SBC_IDX_SYSCFG)
        sbc_decode = 3'h4;
      else if (idx == `SBC_IDX_STATUS)
        sbc_decode = 3'h5;
      else
        sbc_decode = 3'h7;
    end
  endfunction

  // Byte-lane merge of a 16-bit register
  function [15:0] sbc_merge;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  strb;
    input [15:0] wmask;
    reg   [15:0] m;
    begin
      m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      sbc_merge = (old & ~m) | (data & m);
    end
  endfunction

  // Stack pointer mask per size code; reserved codes keep the default
  function [11:0] sbc_spmask;
    input [2:0] code;
    begin
      case (code)
        3'h0:    sbc_spmask = 12'h1ff;
        3'h1:    sbc_spmask = 12'h0ff;
        3'h2:    sbc_spmask = 12'h07f;
        3'h3:    sbc_spmask = 12'h03f;
        3'h4:    sbc_spmask = 12'h3ff;
        3'h7:    sbc_spmask = 12'hfff;
        default: sbc_spmask = 12'h1ff;
      endcase
    end
  endfunction

  wire        aw_take = s_axi_awvalid & ~awfull_reg & ~bvalid_reg;
  wire        w_take  = s_axi_wvalid & ~wfull_reg & ~bvalid_reg;
  wire        ar_take = s_axi_arvalid & ~rvalid_reg;
  wire        wr_go   = awfull_reg & wfull_reg & ~bvalid_reg;
  wire [2:0]  wsel    = awidx_reg[2:0];
  wire [2:0]  rsel    = sbc_decode(s_axi_araddr);
  wire [15:0] win_cur = win_reg[bus_cycle_window];
  wire [2:0]  stk     = syscfg_reg[`SBC_SC_STK_LO+2:`SBC_SC_STK_LO];
  wire        xtal_act = crystal_input ^ xtal_prev_reg;
  wire        oscwd_on = ~syscfg_reg[`SBC_SC_OSCWD_OFF];
  wire [IRQ_PINS-1:0] irq_active = ~(fast_ext_irq_pin ^ fast_irq_high_active) & fast_irq_enable;
  reg  [31:0] rd_mux;
  integer     i;

  always @*
  begin
    case (rsel)
      3'h0, 3'h1, 3'h2, 3'h3: rd_mux = {16'h0000, win_reg[rsel[1:0]]};
      3'h4:    rd_mux = {16'h0000, syscfg_reg};
      3'h5:    rd_mux = {29'h00000000, pdn_reg, pll_sel_reg, lock_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // AXI4-Lite slave channels
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      awfull_reg <= 1'b0;
      wfull_reg  <= 1'b0;
      awidx_reg  <= 16'h0000;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `SBC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `SBC_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        awfull_reg <= 1'b1;
        awidx_reg  <= {13'h0000, sbc_decode(s_axi_awaddr)};
      end
      if (w_take)
      begin
        wfull_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        awfull_reg <= 1'b0;
        wfull_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wsel == 3'h7) ? `SBC_RESP_DECERR : `SBC_RESP_OKAY;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= (rsel == 3'h7) ? `SBC_RESP_DECERR : `SBC_RESP_OKAY;
      end
      else if (rvalid_reg && s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  // Register storage, strap capture and lock
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      syscfg_reg <= `SBC_SC_RESET;
      for (i = 0; i < 4; i = i + 1)
        win_reg[i] <= `SBC_BW_RESET;
      lock_reg <= 1'b0;
      init_reg <= 1'b1;
    end
    else if (init_reg)
    begin
      init_reg <= 1'b0;
      syscfg_reg[`SBC_SC_MEM_ON]   <= external_access_pin;
      syscfg_reg[`SBC_SC_WR_SPLIT] <= ~strap_write_config;
      syscfg_reg[`SBC_SC_HB_OFF]   <= ~external_access_pin & ~strap_bus_type[1];
      if (!external_access_pin)
      begin
        win_reg[0][`SBC_BW_ACTIVE]   <= 1'b1;
        win_reg[0][`SBC_BW_ALE_LONG] <= 1'b1;
        win_reg[0][`SBC_BW_TYPE_LO+1:`SBC_BW_TYPE_LO] <= strap_bus_type;
      end
    end
    else
    begin
      if (end_of_init_instr)
        lock_reg <= 1'b1;
      if (wr_go && wsel == 3'h4 && !lock_reg)
        syscfg_reg <= sbc_merge(syscfg_reg, wdata_reg[15:0], wstrb_reg[1:0], `SBC_SC_WMASK);
      if (wr_go && wsel[2] == 1'b0)
        win_reg[wsel[1:0]] <= sbc_merge(win_reg[wsel[1:0]], wdata_reg[15:0], wstrb_reg[1:0],
                                        `SBC_BW_WMASK);
    end
  end

  // Bidirectional reset pull on soft reset request
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pull_reg     <= 1'b0;
      pull_cnt_reg <= 10'h000;
    end
    else if (soft_reset_req && syscfg_reg[`SBC_SC_BIDIR] && !pull_reg)
    begin
      pull_reg     <= 1'b1;
      pull_cnt_reg <= BIDIR_CYCLES[9:0] - 10'h001;
    end
    else if (pull_reg)
    begin
      if (pull_cnt_reg == 10'h000)
        pull_reg <= 1'b0;
      else
        pull_cnt_reg <= pull_cnt_reg - 10'h001;
    end
  end

  // Oscillator watchdog
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      xtal_prev_reg <= 1'b0;
      idle_cnt_reg  <= 8'h00;
      pll_sel_reg   <= 1'b0;
      pll_off_reg   <= 1'b0;
    end
    else
    begin
      xtal_prev_reg <= crystal_input;
      pll_off_reg   <= pll_bypass & ~oscwd_on;
      if (!pll_bypass || !oscwd_on)
      begin
        idle_cnt_reg <= 8'h00;
        pll_sel_reg  <= 1'b0;
      end
      else if (xtal_act)
        idle_cnt_reg <= 8'h00;
      else if (idle_cnt_reg == `SBC_OWD_IDLE_CYC - 1)
        pll_sel_reg <= 1'b1;
      else
        idle_cnt_reg <= idle_cnt_reg + 8'h01;
    end
  end

  // Power down entry and exit
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pdn_reg      <= 1'b0;
      irq_prev_reg <= {IRQ_PINS{1'b0}};
    end
    else
    begin
      irq_prev_reg <= fast_ext_irq_pin;
      if (!pdn_reg && power_down_instr)
      begin
        if (!syscfg_reg[`SBC_SC_PDN_MODE])
          pdn_reg <= ~nmi_pin_n;
        else
          pdn_reg <= ~|irq_active;
      end
      else if (pdn_reg && syscfg_reg[`SBC_SC_PDN_MODE] && |irq_active)
        pdn_reg <= 1'b0;
    end
  end

  // Decoded configuration outputs
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      share_reg  <= 1'b0;
      lo_wr_reg  <= 1'b0;
      hi_wr_reg  <= 1'b0;
      flash_reg  <= `SBC_FLASH_SEG0;
      spmask_reg <= 12'h1ff;
      sptop_reg  <= `SBC_STACK_TOP;
      circ_reg   <= 1'b1;
      w16_reg    <= 1'b0;
      mux_reg    <= 1'b0;
      ws_reg     <= 4'hf;
      rwd_reg    <= 1'b1;
      end_reg    <= 1'b1;
    end
    else
    begin
      share_reg  <= syscfg_reg[`SBC_SC_SHARE] & syscfg_reg[`SBC_SC_PERIPH_ON] & hold_mode;
      lo_wr_reg  <= syscfg_reg[`SBC_SC_WR_SPLIT];
      hi_wr_reg  <= syscfg_reg[`SBC_SC_WR_SPLIT] & ~syscfg_reg[`SBC_SC_HB_OFF];
      flash_reg  <= syscfg_reg[`SBC_SC_FLASH_HI] ? `SBC_FLASH_SEG1 : `SBC_FLASH_SEG0;
      spmask_reg <= sbc_spmask(stk);
      sptop_reg  <= (stk == 3'h7) ? `SBC_STACK_TOP_1K : `SBC_STACK_TOP;
      circ_reg   <= (stk != 3'h7);
      w16_reg    <= win_cur[`SBC_BW_TYPE_LO+1];
      mux_reg    <= win_cur[`SBC_BW_TYPE_LO];
      ws_reg     <= 4'hf - win_cur[`SBC_BW_WAIT_LO+3:`SBC_BW_WAIT_LO];
      rwd_reg    <= ~win_cur[`SBC_BW_CMD_DLY];
      end_reg    <= ~win_cur[`SBC_BW_RDY_ON] |
                    (ready_pin == win_cur[`SBC_BW_RDY_POL]);
    end
  end

  assign s_axi_awready          = ~awfull_reg & ~bvalid_reg;
  assign s_axi_wready           = ~wfull_reg & ~bvalid_reg;
  assign s_axi_bresp            = bresp_reg;
  assign s_axi_bvalid           = bvalid_reg;
  assign s_axi_arready          = ~rvalid_reg;
  assign s_axi_rdata            = rdata_reg;
  assign s_axi_rresp            = rresp_reg;
  assign s_axi_rvalid           = rvalid_reg;
  assign reset_input_pin_out    = 1'b0;
  assign reset_input_pin_oe     = pull_reg;
  assign ext_master_access_ok   = share_reg;
  assign ext_periph_visible     = syscfg_reg[`SBC_SC_VISIBLE];
  assign ext_periph_on          = syscfg_reg[`SBC_SC_PERIPH_ON];
  assign cpu_clk_from_pll       = pll_sel_reg;
  assign pll_off                = pll_off_reg;
  assign power_down             = pdn_reg;
  assign chip_select_unlatched  = syscfg_reg[`SBC_SC_CS_UNLATCH];
  assign low_byte_write_strobe  = lo_wr_reg;
  assign high_byte_write_strobe = hi_wr_reg;
  assign clock_output_on        = syscfg_reg[`SBC_SC_CLK_OUT];
  assign high_byte_pin_off      = syscfg_reg[`SBC_SC_HB_OFF];
  assign internal_memory_on     = syscfg_reg[`SBC_SC_MEM_ON];
  assign save_code_segment      = ~syscfg_reg[`SBC_SC_SEG_OFF];
  assign flash_base             = flash_reg;
  assign stack_pointer_mask     = spmask_reg;
  assign stack_top              = sptop_reg;
  assign stack_circular         = circ_reg;
  assign bus_width16            = w16_reg;
  assign bus_multiplexed        = mux_reg;
  assign wait_states            = ws_reg;
  assign rw_cmd_delayed         = rwd_reg;
  assign bus_cycle_may_end      = end_reg;

endmodule
`default_nettype wire

/* verification/sbc_regs_assertions.sv */
// Concurrent checks on the configuration register bank ports
`default_nettype none
module sbc_regs_assertions #(
  parameter integer BIDIR_CYCLES = 512
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        end_of_init_instr,
  input wire logic        soft_reset_req,
  input wire logic        hold_mode,
  input wire logic        pll_bypass,
  input wire logic        reset_input_pin_out,
  input wire logic        reset_input_pin_oe,
  input wire logic        ext_master_access_ok,
  input wire logic        pll_off,
  input wire logic        clock_output_on,
  input wire logic [11:0] stack_pointer_mask,
  input wire logic [15:0] stack_top,
  input wire logic        stack_circular
);
  logic        lock_reg;
  logic        lock_old_reg;
  logic [15:0] pull_cnt_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Lock seen two edges back; length of the reset pin pull
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      lock_reg     <= 1'h0;
      lock_old_reg <= 1'h0;
      pull_cnt_reg <= 16'h0;
    end
    else
    begin
      lock_reg     <= lock_reg | end_of_init_instr;
      lock_old_reg <= lock_reg;
      pull_cnt_reg <= reset_input_pin_oe ? pull_cnt_reg + 16'h1 : 16'h0;
    end
  end
  a_lock_fixed: assert property (lock_old_reg |-> $stable(clock_output_on))
    else $error("clock output changed after lock");
  a_share_hold: assert property (!$past(hold_mode) |-> !ext_master_access_ok)
    else $error("outside access granted out of hold");
  a_pull_level: assert property (reset_input_pin_oe |-> !reset_input_pin_out)
    else $error("reset pin driven high");
  a_pull_length: assert property ($fell(reset_input_pin_oe) |-> pull_cnt_reg == BIDIR_CYCLES)
    else $error("reset pull length wrong");
  a_pull_cause: assert property ($rose(reset_input_pin_oe) |-> $past(soft_reset_req))
    else $error("reset pull without soft reset");
  a_pll_bypass: assert property (!$past(pll_bypass) |-> !pll_off)
    else $error("pll off without bypass");
  a_stack_full: assert property (!stack_circular |-> stack_pointer_mask == 12'hfff && stack_top == 16'hfdfe)
    else $error("non circular stack shape wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
endmodule
bind sbc_regs sbc_regs_assertions #(.BIDIR_CYCLES(BIDIR_CYCLES)) u_sbc_chk (
  .core_clk(core_clk), .rst_n(rst_n), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .end_of_init_instr(end_of_init_instr),
  .soft_reset_req(soft_reset_req), .hold_mode(hold_mode), .pll_bypass(pll_bypass),
  .reset_input_pin_out(reset_input_pin_out), .reset_input_pin_oe(reset_input_pin_oe),
  .ext_master_access_ok(ext_master_access_ok), .pll_off(pll_off), .clock_output_on(clock_output_on),
  .stack_pointer_mask(stack_pointer_mask), .stack_top(stack_top), .stack_circular(stack_circular));
`default_nettype wire

/* verification/sbc_regs_tb.sv */
// Self-checking testbench for the configuration register bank
`include "sbc_map.vh"
`default_nettype none
module sbc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer      BIDIR = 8;
  localparam logic [17:0] A_W0  = {`SBC_IDX_BUSWIN0, 2'h0};
  localparam logic [17:0] A_SC  = {`SBC_IDX_SYSCFG, 2'h0};
  localparam logic [17:0] A_W1  = {`SBC_IDX_BUSWIN1, 2'h0};
  localparam logic [17:0] A_ST  = {`SBC_IDX_STATUS, 2'h0};
  localparam logic [11:0] MASKS [8] = '{12'h1ff, 12'h0ff, 12'h07f, 12'h03f, 12'h3ff, 12'h1ff, 12'h1ff, 12'hfff};
  logic        core_clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  logic        eoi = 1'h0, pwd = 1'h0, srst = 1'h0, acc_pin = 1'h1, wc = 1'h0, xt = 1'h0, byp = 1'h0;
  logic        nmi_n = 1'h1, hold = 1'h0, rdy = 1'h0;
  logic [17:0] awa = 18'h0, ara = 18'h0;
  logic [31:0] wd = 32'h0, rdv;
  logic [3:0]  wstb = 4'h0;
  logic [1:0]  bt = 2'h2, win = 2'h0, wresp, rrs;
  logic [7:0]  irq = 8'h0, ien = 8'h0, ihi = 8'hff;
  wire         awr, wrdy, bv, arr, rv, oe, rpo, acc, vis, xon, fpll, poff, pdn, csu, lbw, hbw, clko, hbo;
  wire         imo, scs, scirc, bw16, bmx, rwd, mend;
  wire [1:0]   br, rr;
  wire [31:0]  rdat;
  wire [23:0]  fb;
  wire [11:0]  spm;
  wire [15:0]  stp;
  wire [3:0]   wst;
  int          mismatches = 0, checks_done = 0;
  sbc_regs #(.BIDIR_CYCLES(BIDIR)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(wstb), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .end_of_init_instr(eoi),
    .power_down_instr(pwd), .soft_reset_req(srst), .external_access_pin(acc_pin), .strap_bus_type(bt),
    .strap_write_config(wc), .crystal_input(xt), .pll_bypass(byp), .nmi_pin_n(nmi_n), .fast_ext_irq_pin(irq),
    .fast_irq_enable(ien), .fast_irq_high_active(ihi), .hold_mode(hold), .bus_cycle_window(win),
    .ready_pin(rdy), .reset_input_pin_out(rpo), .reset_input_pin_oe(oe), .ext_master_access_ok(acc),
    .ext_periph_visible(vis), .ext_periph_on(xon), .cpu_clk_from_pll(fpll), .pll_off(poff), .power_down(pdn),
    .chip_select_unlatched(csu), .low_byte_write_strobe(lbw), .high_byte_write_strobe(hbw),
    .clock_output_on(clko), .high_byte_pin_off(hbo), .internal_memory_on(imo), .save_code_segment(scs),
    .flash_base(fb), .stack_pointer_mask(spm), .stack_top(stp), .stack_circular(scirc), .bus_width16(bw16),
    .bus_multiplexed(bmx), .wait_states(wst), .rw_cmd_delayed(rwd), .bus_cycle_may_end(mend));
  always #4 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic do_reset;
    rst_n <= 1'h0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge core_clk);
    awa <= a;
    wd <= {16'h0, d};
    wstb <= 4'h3;
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    while (aw || w)
    begin
      @(posedge core_clk);
      aw = aw && !awr;
      w = w && !wrdy;
      awv <= aw;
      wv <= w;
    end
    do @(posedge core_clk); while (!bv);
    bre <= 1'h0;
    wresp = br;
  endtask
  task automatic rd(input logic [17:0] a);
    @(posedge core_clk);
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    do @(posedge core_clk); while (!arr);
    arv <= 1'h0;
    do @(posedge core_clk); while (!rv);
    rre <= 1'h0;
    rdv = rdat;
    rrs = rr;
  endtask
  task automatic rchk(input string nm, input logic [17:0] a, input logic [15:0] e);
    rd(a);
    chk(nm, {rrs, rdv[29:0]}, {16'h0, e});
  endtask
  task automatic pd_pulse;
    pwd <= 1'h1;
    @(posedge core_clk);
    pwd <= 1'h0;
    settle;
  endtask
  task automatic t_strap;
    rchk("sys_strap", A_SC, 16'h0480);
    rchk("win0_ea_hi", A_W0, 16'h0000);
    chk("mem_on", imo, 1'h1);
    chk("hbw", hbw, 1'h1);
    chk("sp_mask", spm, 12'h1ff);
    acc_pin <= 1'h0;
    wc <= 1'h1;
    bt <= 2'h1;
    do_reset;
    rchk("sys_strap2", A_SC, 16'h0200);
    rchk("win0_ea_lo", A_W0, 16'h0640);
    chk("lbw", lbw, 1'h0);
  endtask
  task automatic t_window;
    logic [15:0] v;
    win <= 2'h1;
    settle;
    chk("ws_reset", wst, 4'hf);
    wr(A_W1, 16'hffff);
    rchk("win1_mask", A_W1, 16'hf6ff);
    for (int c = 0; c < 4; c++)
    begin
      v = {2'h0, c[1], 1'h1, 4'h0, c[1:0], 1'h0, c[0], 4'(c * 5)};
      wr(A_W1, v);
      settle;
      chk("bw16", bw16, c[1]);
      chk("bmux", bmx, c[0]);
      chk("wst", wst, 15 - c * 5);
      chk("rwd", rwd, !c[0]);
      chk("rdy_lo", mend, !c[1]);
      rdy <= 1'h1;
      settle;
      chk("rdy_hi", mend, c[1]);
      rdy <= 1'h0;
    end
  endtask
  task automatic t_sys;
    logic [15:0] v;
    for (int k = 0; k < 8; k++)
    begin
      v = {k[2:0], k[0], k[1], k[2], k[0], k[1], k[2], k[0], 3'h0, k[1], k[0], 1'h0};
      wr(A_SC, v);
      settle;
      rchk("sys", A_SC, v);
      chk("sp_mask", spm, MASKS[k]);
      chk("sp_top", stp, k == 7 ? 16'hfdfe : 16'hfbfe);
      chk("sp_circ", scirc, k != 7);
      chk("flash", fb, k[0] ? 24'h010000 : 24'h0);
      chk("seg", scs, !k[1]);
      chk("hb_off", hbo, k[0]);
      chk("clko", clko, k[1]);
      chk("cs_unl", csu, k[0]);
      chk("hbw", hbw, k[2] & !k[0]);
      chk("ext_periph_on", xon, k[1]);
      chk("vis", vis, k[0]);
    end
  endtask
  task automatic t_misc;
    int n;
    n = 0;
    wr(A_SC, 16'h0005);
    hold <= 1'h1;
    settle;
    chk("share", acc, 1'h1);
    wr(A_SC, 16'h0004);
    settle;
    chk("no_share", acc, 1'h0);
    hold <= 1'h0;
    wr(A_SC, 16'h0008);
    srst <= 1'h1;
    @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    while (oe && n < 600)
    begin
      n++;
      @(posedge core_clk);
    end
    chk("pull_len", n, BIDIR);
    wr(A_SC, 16'h0000);
    srst <= 1'h1;
    @(posedge core_clk);
    srst <= 1'h0;
    settle;
    chk("no_pull", oe, 1'h0);
    byp <= 1'h1;
    repeat (200)
    begin
      @(posedge core_clk);
      xt <= !xt;
    end
    chk("owd_active", fpll, 1'h0);
    chk("pll_on", poff, 1'h0);
    repeat (140) @(posedge core_clk);
    chk("owd_idle", fpll, 1'h1);
    wr(A_SC, 16'h0010);
    settle;
    chk("pll_off", poff, 1'h1);
    chk("xtal_clk", fpll, 1'h0);
    byp <= 1'h0;
  endtask
  task automatic t_pdn;
    pd_pulse;
    chk("pd_nmi_hi", pdn, 1'h0);
    nmi_n <= 1'h0;
    pd_pulse;
    chk("pd_nmi_lo", pdn, 1'h1);
    nmi_n <= 1'h1;
    settle;
    chk("pd_stay", pdn, 1'h1);
    do_reset;
    chk("pd_reset", pdn, 1'h0);
    wr(A_SC, 16'h0020);
    ien <= 8'h01;
    irq <= 8'h01;
    pd_pulse;
    chk("pd_pin_act", pdn, 1'h0);
    irq <= 8'h02;
    pd_pulse;
    chk("pd_enter", pdn, 1'h1);
    irq <= 8'h03;
    settle;
    chk("pd_wake", pdn, 1'h0);
    irq <= 8'h00;
  endtask
  task automatic t_lock;
    wr(A_SC, 16'h1234);
    eoi <= 1'h1;
    @(posedge core_clk);
    eoi <= 1'h0;
    wr(A_SC, 16'habcd);
    chk("lock_resp", wresp, 2'h0);
    rchk("locked", A_SC, 16'h1234);
    wr(A_W1, 16'h0005);
    rchk("win1_open", A_W1, 16'h0005);
    rchk("status", A_ST, 16'h0001);
    wr(18'h00010, 16'hffff);
    rd(18'h00010);
    chk("unmapped", {wresp, rrs, rdv[27:0]}, 32'hf0000000);
  endtask
  initial
  begin
    do_reset;
    t_strap;
    t_window;
    t_sys;
    t_misc;
    t_pdn;
    t_lock;
    test_done;
  end
  initial
  begin
    #100000;
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
